// File: src/dtu_regs.svh
`ifndef DTU_REGS_SVH
`define DTU_REGS_SVH

// ----------------------------------------------------------------
// Instruction codes on instr_op
// ----------------------------------------------------------------
`define DTU_OP_NOP            4'h0
`define DTU_OP_LOAD_IMM       4'h1
`define DTU_OP_STORE_MEM      4'h2
`define DTU_OP_LOAD_MEM       4'h3
`define DTU_OP_LOAD_IO        4'h4
`define DTU_OP_STORE_IO       4'h5
`define DTU_OP_TIMER_TO_WORD  4'h6
`define DTU_OP_WORD_TO_TIMER  4'h7
`define DTU_OP_ADD_IMM        4'h8
`define DTU_OP_SUB_IMM        4'h9
`define DTU_OP_SET_BIT_IO     4'hA
`define DTU_OP_CLR_BIT_IO     4'hB

// ----------------------------------------------------------------
// Software register offsets
// ----------------------------------------------------------------
`define DTU_REG_ACC           8'h00
`define DTU_REG_FLAGS         8'h04
`define DTU_REG_TMODE         8'h08
`define DTU_REG_TCNT_LO       8'h0C
`define DTU_REG_TCNT_HI       8'h10
`define DTU_REG_STATUS        8'h14

// ----------------------------------------------------------------
// Flag bit positions
// ----------------------------------------------------------------
`define DTU_FLAG_Z            0
`define DTU_FLAG_C            1
`define DTU_FLAG_AC           2
`define DTU_FLAG_OV           3

// ----------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------
`define DTU_STAT_BUSY         0
`define DTU_STAT_BIT_ERR      1

// ----------------------------------------------------------------
// Timer mode register and limits
// ----------------------------------------------------------------
`define DTU_IO_TMODE          8'h06
`define DTU_TMODE_RUN_BIT     5
`define DTU_BIT_ADDR_MAX      8'h3F
`define DTU_ACC_RESET         8'h00
`define DTU_FLAGS_RESET       4'h0
`define DTU_TMODE_RESET       8'h00
`define DTU_TCNT_RESET        16'h0000

`endif

// File: src/dtu_pkg.sv
package dtu_pkg;

    // Execution sequencer states
    typedef enum logic [1:0] {
        DTU_S_IDLE,
        DTU_S_STROBE,
        DTU_S_DATA,
        DTU_S_WRITE
    } dtu_state_t;

endpackage : dtu_pkg

// File: src/dtu_wide_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "dtu_regs.svh"

module dtu_wide_timer #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             run,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_value,
    output logic      [WIDTH-1:0] count
);

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // Load beats counting in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= WIDTH'(`DTU_TCNT_RESET);
        end else if (load) begin
            count <= load_value;
        end else if (run) begin
            count <= count + WIDTH'(1);
        end
    end

endmodule : dtu_wide_timer
`default_nettype wire

// File: src/dtu_core.sv
// Behaviour
// - Load immediate into accumulator, flags kept
// - Store accumulator to memory, flags kept
// - Load memory byte, zero flag from byte
// - Load IO register, zero flag from value
// - Store accumulator to IO, flags kept
// - Copy timer count to memory word
// - Load timer count from memory word
// - Zero flag set on zero result
// - Carry flag: add carry, subtract borrow
// - Half carry from low nibble
// - Overflow on signed range exceeded
// - Bit operands only at addresses 0..0x3F
// - Mode bit 5 runs or stops timer
`timescale 1ns/1ps
`default_nettype none
`include "dtu_regs.svh"

module dtu_core (
    input  wire logic       clk,
    input  wire logic       rst,
    // Instruction stream
    input  wire logic       instr_valid,
    input  wire logic [3:0] instr_op,
    input  wire logic [7:0] instr_addr,
    input  wire logic [7:0] instr_imm,
    output logic            instr_ready,
    output logic            instr_done,
    output logic            instr_error,
    // Data memory
    output logic      [7:0] mem_addr,
    output logic      [7:0] mem_wdata,
    output logic            mem_we,
    output logic            mem_re,
    input  wire logic [7:0] mem_rdata,
    // IO space
    output logic      [7:0] io_addr,
    output logic      [7:0] io_wdata,
    output logic            io_we,
    output logic            io_re,
    input  wire logic [7:0] io_rdata,
    // Software register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_we,
    input  wire logic       reg_re,
    output logic      [7:0] reg_rdata
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    dtu_pkg::dtu_state_t state;      // Sequencer state
    dtu_pkg::dtu_state_t next_state;
    logic [3:0]  op;                 // Instruction in flight
    logic [3:0]  next_op;
    logic        hi;                 // Second byte of a word
    logic        next_hi;
    logic [7:0]  waddr;              // Operand address
    logic [7:0]  next_waddr;
    logic [7:0]  bitmask;            // One-hot bit for bit ops
    logic [7:0]  next_bitmask;
    logic [7:0]  lo_buf;             // Low byte of word read
    logic [7:0]  next_lo_buf;
    logic [15:0] snap;               // Timer count snapshot
    logic [15:0] next_snap;
    logic [7:0]  acc;                // Accumulator
    logic [7:0]  next_acc;
    logic [3:0]  flags;              // Z, C, AC, OV
    logic [3:0]  next_flags;
    logic [7:0]  tmode;              // Timer mode register
    logic [7:0]  next_tmode;
    logic        bit_err;            // Sticky bit-address fault
    logic        next_bit_err;
    logic        next_done;
    logic        next_error;
    logic        tload;              // Timer load pulse
    logic        next_tload;
    logic [15:0] tload_val;          // Timer load value
    logic [15:0] next_tload_val;
    logic [15:0] tcount;             // Live timer count
    logic [7:0]  next_mem_addr;
    logic [7:0]  next_mem_wdata;
    logic        next_mem_we;
    logic        next_mem_re;
    logic [7:0]  next_io_addr;
    logic [7:0]  next_io_wdata;
    logic        next_io_we;
    logic        next_io_re;
    logic [7:0]  next_reg_rdata;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire       take      = instr_valid && (state == dtu_pkg::DTU_S_IDLE);
    wire       is_tmode  = (instr_addr == `DTU_IO_TMODE);
    wire       bit_ok    = (instr_addr <= `DTU_BIT_ADDR_MAX);
    wire [7:0] imm_mask  = 8'h01 << instr_imm[2:0];
    wire       op_io     = (op == `DTU_OP_LOAD_IO)
                        || (op == `DTU_OP_SET_BIT_IO)
                        || (op == `DTU_OP_CLR_BIT_IO);
    wire [7:0] rd_byte   = op_io ? io_rdata : mem_rdata;
    wire [7:0] bit_new   = (op == `DTU_OP_SET_BIT_IO) ? (rd_byte | bitmask)
                                                      : (rd_byte & ~bitmask);
    wire [7:0] tmode_bit = (instr_op == `DTU_OP_SET_BIT_IO)
                        ? (tmode | imm_mask) : (tmode & ~imm_mask);

    // ------------------------------------------------------------
    // Arithmetic
    // ------------------------------------------------------------
    wire [8:0] add_sum  = {1'b0, acc} + {1'b0, instr_imm};
    wire [4:0] add_nib  = {1'b0, acc[3:0]} + {1'b0, instr_imm[3:0]};
    wire [8:0] sub_dif  = {1'b0, acc} - {1'b0, instr_imm};
    wire [4:0] sub_nib  = {1'b0, acc[3:0]} - {1'b0, instr_imm[3:0]};
    wire       add_ov   = (acc[7] == instr_imm[7])
                       && (add_sum[7] != acc[7]);
    wire       sub_ov   = (acc[7] != instr_imm[7])
                       && (sub_dif[7] != acc[7]);

    // ------------------------------------------------------------
    // Sequencer and datapath next values
    // ------------------------------------------------------------
    always_comb begin
        next_state     = state;
        next_op        = op;
        next_hi        = hi;
        next_waddr     = waddr;
        next_bitmask   = bitmask;
        next_lo_buf    = lo_buf;
        next_snap      = snap;
        next_acc       = acc;
        next_flags     = flags;
        next_tmode     = tmode;
        next_bit_err   = bit_err;
        next_done      = 1'b0;
        next_error     = 1'b0;
        next_tload     = 1'b0;
        next_tload_val = tload_val;
        next_mem_addr  = mem_addr;
        next_mem_wdata = mem_wdata;
        next_mem_we    = 1'b0;
        next_mem_re    = 1'b0;
        next_io_addr   = io_addr;
        next_io_wdata  = io_wdata;
        next_io_we     = 1'b0;
        next_io_re     = 1'b0;
        // Software writes; instruction results below override
        if (reg_we) begin
            case (reg_addr)
                `DTU_REG_ACC:    next_acc   = reg_wdata;
                `DTU_REG_FLAGS:  next_flags = reg_wdata[3:0];
                `DTU_REG_TMODE:  next_tmode = reg_wdata;
                `DTU_REG_STATUS: begin
                    // Write one clears the fault bit
                    if (reg_wdata[`DTU_STAT_BIT_ERR]) begin
                        next_bit_err = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        case (state)
            dtu_pkg::DTU_S_IDLE: begin
                if (take) begin
                    next_op      = instr_op;
                    next_hi      = 1'b0;
                    next_waddr   = instr_addr;
                    next_bitmask = imm_mask;
                    case (instr_op)
                        `DTU_OP_LOAD_IMM: begin
                            next_acc  = instr_imm;
                            next_done = 1'b1;
                        end
                        `DTU_OP_ADD_IMM: begin
                            next_acc = add_sum[7:0];
                            next_flags[`DTU_FLAG_Z] =
                                (add_sum[7:0] == 8'h00);
                            next_flags[`DTU_FLAG_C]  = add_sum[8];
                            next_flags[`DTU_FLAG_AC] = add_nib[4];
                            next_flags[`DTU_FLAG_OV] = add_ov;
                            next_done = 1'b1;
                        end
                        `DTU_OP_SUB_IMM: begin
                            next_acc = sub_dif[7:0];
                            next_flags[`DTU_FLAG_Z] =
                                (sub_dif[7:0] == 8'h00);
                            next_flags[`DTU_FLAG_C]  = sub_dif[8];
                            next_flags[`DTU_FLAG_AC] = sub_nib[4];
                            next_flags[`DTU_FLAG_OV] = sub_ov;
                            next_done = 1'b1;
                        end
                        `DTU_OP_STORE_MEM: begin
                            next_mem_addr  = instr_addr;
                            next_mem_wdata = acc;
                            next_mem_we    = 1'b1;
                            next_state     = dtu_pkg::DTU_S_WRITE;
                        end
                        `DTU_OP_LOAD_MEM: begin
                            next_mem_addr = instr_addr;
                            next_mem_re   = 1'b1;
                            next_state    = dtu_pkg::DTU_S_STROBE;
                        end
                        `DTU_OP_STORE_IO: begin
                            if (is_tmode) begin
                                next_tmode = acc;
                                next_done  = 1'b1;
                            end else begin
                                next_io_addr  = instr_addr;
                                next_io_wdata = acc;
                                next_io_we    = 1'b1;
                                next_state    = dtu_pkg::DTU_S_WRITE;
                            end
                        end
                        `DTU_OP_LOAD_IO: begin
                            if (is_tmode) begin
                                next_acc = tmode;
                                next_flags[`DTU_FLAG_Z] = (tmode == 8'h00);
                                next_done = 1'b1;
                            end else begin
                                next_io_addr = instr_addr;
                                next_io_re   = 1'b1;
                                next_state   = dtu_pkg::DTU_S_STROBE;
                            end
                        end
                        `DTU_OP_SET_BIT_IO, `DTU_OP_CLR_BIT_IO: begin
                            if (!bit_ok) begin
                                next_error   = 1'b1;
                                next_bit_err = 1'b1;
                                next_done    = 1'b1;
                            end else if (is_tmode) begin
                                next_tmode = tmode_bit;
                                next_done  = 1'b1;
                            end else begin
                                next_io_addr = instr_addr;
                                next_io_re   = 1'b1;
                                next_state   = dtu_pkg::DTU_S_STROBE;
                            end
                        end
                        `DTU_OP_TIMER_TO_WORD: begin
                            next_snap      = tcount;
                            next_mem_addr  = instr_addr;
                            next_mem_wdata = tcount[7:0];
                            next_mem_we    = 1'b1;
                            next_state     = dtu_pkg::DTU_S_WRITE;
                        end
                        `DTU_OP_WORD_TO_TIMER: begin
                            next_mem_addr = instr_addr;
                            next_mem_re   = 1'b1;
                            next_state    = dtu_pkg::DTU_S_STROBE;
                        end
                        default: begin
                            next_done = 1'b1;
                        end
                    endcase
                end
            end
            dtu_pkg::DTU_S_STROBE: begin
                // Read strobe is on the bus; data follows
                next_state = dtu_pkg::DTU_S_DATA;
            end
            dtu_pkg::DTU_S_DATA: begin
                case (op)
                    `DTU_OP_LOAD_MEM, `DTU_OP_LOAD_IO: begin
                        next_acc = rd_byte;
                        next_flags[`DTU_FLAG_Z] = (rd_byte == 8'h00);
                        next_done  = 1'b1;
                        next_state = dtu_pkg::DTU_S_IDLE;
                    end
                    `DTU_OP_SET_BIT_IO, `DTU_OP_CLR_BIT_IO: begin
                        // Read-modify-write of one IO bit
                        next_io_wdata = bit_new;
                        next_io_we    = 1'b1;
                        next_state    = dtu_pkg::DTU_S_WRITE;
                    end
                    `DTU_OP_WORD_TO_TIMER: begin
                        if (!hi) begin
                            next_lo_buf   = mem_rdata;
                            next_hi       = 1'b1;
                            next_mem_addr = waddr + 8'h01;
                            next_mem_re   = 1'b1;
                            next_state    = dtu_pkg::DTU_S_STROBE;
                        end else begin
                            next_tload_val = {mem_rdata, lo_buf};
                            next_tload     = 1'b1;
                            next_done      = 1'b1;
                            next_state     = dtu_pkg::DTU_S_IDLE;
                        end
                    end
                    default: begin
                        next_done  = 1'b1;
                        next_state = dtu_pkg::DTU_S_IDLE;
                    end
                endcase
            end
            dtu_pkg::DTU_S_WRITE: begin
                if ((op == `DTU_OP_TIMER_TO_WORD) && !hi) begin
                    next_hi        = 1'b1;
                    next_mem_addr  = waddr + 8'h01;
                    next_mem_wdata = snap[15:8];
                    next_mem_we    = 1'b1;
                end else begin
                    next_done  = 1'b1;
                    next_state = dtu_pkg::DTU_S_IDLE;
                end
            end
            default: begin
                next_state = dtu_pkg::DTU_S_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------
    wire busy = (state != dtu_pkg::DTU_S_IDLE);
    always_comb begin
        next_reg_rdata = 8'h00;
        if (reg_re) begin
            case (reg_addr)
                `DTU_REG_ACC:     next_reg_rdata = acc;
                `DTU_REG_FLAGS:   next_reg_rdata = {4'h0, flags};
                `DTU_REG_TMODE:   next_reg_rdata = tmode;
                `DTU_REG_TCNT_LO: next_reg_rdata = tcount[7:0];
                `DTU_REG_TCNT_HI: next_reg_rdata = tcount[15:8];
                `DTU_REG_STATUS:  next_reg_rdata = {6'h00, bit_err, busy};
                default:          next_reg_rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Sequencer registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state   <= dtu_pkg::DTU_S_IDLE;
            op      <= `DTU_OP_NOP;
            hi      <= 1'b0;
            waddr   <= 8'h00;
            bitmask <= 8'h00;
            lo_buf  <= 8'h00;
            snap    <= 16'h0000;
        end else begin
            state   <= next_state;
            op      <= next_op;
            hi      <= next_hi;
            waddr   <= next_waddr;
            bitmask <= next_bitmask;
            lo_buf  <= next_lo_buf;
            snap    <= next_snap;
        end
    end

    // ------------------------------------------------------------
    // Architectural registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc       <= `DTU_ACC_RESET;
            flags     <= `DTU_FLAGS_RESET;
            tmode     <= `DTU_TMODE_RESET;
            bit_err   <= 1'b0;
            tload     <= 1'b0;
            tload_val <= `DTU_TCNT_RESET;
            reg_rdata <= 8'h00;
        end else begin
            acc       <= next_acc;
            flags     <= next_flags;
            tmode     <= next_tmode;
            bit_err   <= next_bit_err;
            tload     <= next_tload;
            tload_val <= next_tload_val;
            reg_rdata <= next_reg_rdata;
        end
    end

    // ------------------------------------------------------------
    // Bus outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_addr    <= 8'h00;
            mem_wdata   <= 8'h00;
            mem_we      <= 1'b0;
            mem_re      <= 1'b0;
            io_addr     <= 8'h00;
            io_wdata    <= 8'h00;
            io_we       <= 1'b0;
            io_re       <= 1'b0;
            instr_done  <= 1'b0;
            instr_error <= 1'b0;
        end else begin
            mem_addr    <= next_mem_addr;
            mem_wdata   <= next_mem_wdata;
            mem_we      <= next_mem_we;
            mem_re      <= next_mem_re;
            io_addr     <= next_io_addr;
            io_wdata    <= next_io_wdata;
            io_we       <= next_io_we;
            io_re       <= next_io_re;
            instr_done  <= next_done;
            instr_error <= next_error;
        end
    end

    assign instr_ready = !busy;

    // ------------------------------------------------------------
    // Sixteen-bit timer
    // ------------------------------------------------------------
    dtu_wide_timer #(
        .WIDTH (16)
    ) u_sixteen_bit_timer (
        .clk        (clk),
        .rst        (rst),
        .run        (tmode[`DTU_TMODE_RUN_BIT]),
        .load       (tload),
        .load_value (tload_val),
        .count      (tcount)
    );

endmodule : dtu_core
`default_nettype wire

// File: verif/dtu_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "dtu_regs.svh"
module dtu_core_asserts (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       instr_valid,
    input wire logic [3:0] instr_op,
    input wire logic [7:0] instr_addr,
    input wire logic       instr_ready,
    input wire logic       instr_done,
    input wire logic       instr_error,
    input wire logic [7:0] mem_addr,
    input wire logic       mem_we,
    input wire logic       mem_re,
    input wire logic [7:0] io_addr,
    input wire logic       io_we,
    input wire logic       io_re
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire [7:0] a   = instr_addr;  // Operand address
    wire       ext = a != `DTU_IO_TMODE;  // IO outside the core
    wire [3:0] tk  = (instr_valid && instr_ready) ? instr_op : 4'hF;
    wire       bop = tk == `DTU_OP_SET_BIT_IO || tk == `DTU_OP_CLR_BIT_IO;
    a_limm_quick: assert property (tk == `DTU_OP_LOAD_IMM
        |=> instr_done && !mem_we && !io_we) else $error("load imm");
    a_store_mem: assert property (tk == `DTU_OP_STORE_MEM
        |=> mem_we && mem_addr == $past(a)) else $error("store mem");
    a_load_mem: assert property (tk == `DTU_OP_LOAD_MEM
        |=> mem_re && mem_addr == $past(a) ##2 instr_done) else $error("ld");
    a_load_io: assert property (tk == `DTU_OP_LOAD_IO && ext
        |=> io_re && io_addr == $past(a)) else $error("load io");
    a_store_io: assert property (tk == `DTU_OP_STORE_IO && ext
        |=> io_we && io_addr == $past(a)) else $error("store io");
    a_word_out: assert property (tk == `DTU_OP_TIMER_TO_WORD
        |=> mem_we && mem_addr == $past(a) ##1 mem_we
        && mem_addr == $past(a, 2) + 8'h01) else $error("word out");
    a_word_in: assert property (tk == `DTU_OP_WORD_TO_TIMER
        |=> mem_re && mem_addr == $past(a) ##2 mem_re
        && mem_addr == $past(a, 3) + 8'h01) else $error("word in");
    a_bit_limit: assert property (bop && a > `DTU_BIT_ADDR_MAX
        |=> instr_error && !io_re && !io_we) else $error("bit limit");
    a_err_cause: assert property (instr_error |-> instr_done
        && $past(bop, 1) && $past(a) > 8'h3F) else $error("stray error");
    c_load_mem: cover property (tk == `DTU_OP_LOAD_MEM);
    c_refused: cover property (instr_error);
    c_word_in: cover property (tk == `DTU_OP_WORD_TO_TIMER);
endmodule : dtu_core_asserts
bind dtu_core dtu_core_asserts u_chk (.clk, .rst, .instr_valid, .instr_op,
    .instr_addr, .instr_ready, .instr_done, .instr_error, .mem_addr,
    .mem_we, .mem_re, .io_addr, .io_we, .io_re);
`default_nettype wire

// File: verif/dtu_byte_space.sv
`timescale 1ns/1ps
`default_nettype none
module dtu_byte_space (
    input  wire logic       clk,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       we,
    input  wire logic       re,
    output logic      [7:0] rdata
);
    logic [7:0] m [256];  // Byte store, bench may preload
    // Data only in the cycle after re, toggled garbage otherwise
    always @(posedge clk) begin
        if (we) m[addr] <= wdata;
        rdata <= re ? m[addr] : ~rdata;
    end
endmodule : dtu_byte_space
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dtu_regs.svh"
module testbench;
    logic       clk = 0, rst = 1, iv = 0, rwe = 0, rre = 0, e;
    logic [3:0] op = '0;
    logic [7:0] ia = '0, ii = '0, ra = '0, rw = '0, rd, rd2;
    logic [7:0] ma, mw, mr, xa, xw, xr, rr;
    logic       rdy, dn, er, mwe, mre, xwe, xre;
    int         errors = 0, comparisons = 0;
    initial forever #20 clk = ~clk;
    dtu_core dut (.clk(clk), .rst(rst), .instr_valid(iv), .instr_op(op),
        .instr_addr(ia), .instr_imm(ii), .instr_ready(rdy), .instr_done(dn),
        .instr_error(er), .mem_addr(ma), .mem_wdata(mw), .mem_we(mwe),
        .mem_re(mre), .mem_rdata(mr), .io_addr(xa), .io_wdata(xw),
        .io_we(xwe), .io_re(xre), .io_rdata(xr), .reg_addr(ra),
        .reg_wdata(rw), .reg_we(rwe), .reg_re(rre), .reg_rdata(rr));
    dtu_byte_space mem (.clk(clk), .addr(ma), .wdata(mw), .we(mwe),
        .re(mre), .rdata(mr));
    dtu_byte_space io (.clk(clk), .addr(xa), .wdata(xw), .we(xwe),
        .re(xre), .rdata(xr));
    task automatic chk(input logic [15:0] s, x);
        comparisons++;
        if (s !== x) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask : chk
    task automatic complete_run;
        if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    task automatic wreg(input logic [7:0] a, d);
        @(posedge clk);
        rwe <= 1'b1;
        ra  <= a;
        rw  <= d;
        @(posedge clk);
        rwe <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rre <= 1'b1;
        ra  <= a;
        @(posedge clk);
        rre <= 1'b0;
        #1 d = rr;
    endtask : rreg
    task automatic exp_reg(input logic [7:0] a, x);
        rreg(a, rd);
        chk(rd, x);
    endtask : exp_reg
    task automatic run_op(input logic [3:0] o, input logic [7:0] a, i);
        int n;
        @(posedge clk);
        iv <= 1'b1;
        op <= o;
        ia <= a;
        ii <= i;
        @(posedge clk);
        iv <= 1'b0;
        n = 0;
        #1;
        while (dn !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1 n++;
        end
        e = er;
        if (n >= 20) begin
            errors++;
            complete_run();
        end
    endtask : run_op
    task automatic t_moves;
        wreg(`DTU_REG_FLAGS, 8'h0E);
        run_op(`DTU_OP_LOAD_IMM, 8'h00, 8'h5A);
        exp_reg(`DTU_REG_ACC, 8'h5A);
        run_op(`DTU_OP_STORE_MEM, 8'h20, 8'h00);
        chk(mem.m[8'h20], 8'h5A);
        exp_reg(`DTU_REG_FLAGS, 8'h0E);
        mem.m[8'h30] = 8'h00;
        run_op(`DTU_OP_LOAD_MEM, 8'h30, 8'h00);
        exp_reg(`DTU_REG_FLAGS, 8'h0F);
        io.m[8'h10] = 8'h81;
        run_op(`DTU_OP_LOAD_IO, 8'h10, 8'h00);
        exp_reg(`DTU_REG_ACC, 8'h81);
        run_op(`DTU_OP_STORE_IO, 8'h11, 8'h00);
        chk(io.m[8'h11], 8'h81);
        exp_reg(`DTU_REG_FLAGS, 8'h0E);
    endtask : t_moves
    task automatic t_alu;
        logic [31:0] v [4] = '{32'h7F01880C, 32'hFF018007, 32'h00019FF6,
                               32'h800197FC};
        for (int k = 0; k < 4; k++) begin
            wreg(`DTU_REG_ACC, v[k][31:24]);
            run_op(v[k][15:12], 8'h00, v[k][23:16]);
            exp_reg(`DTU_REG_ACC, v[k][11:4]);
            exp_reg(`DTU_REG_FLAGS, {4'h0, v[k][3:0]});
        end
    endtask : t_alu
    task automatic t_timer;
        mem.m[8'h40] = 8'h34;
        mem.m[8'h41] = 8'h12;
        run_op(`DTU_OP_WORD_TO_TIMER, 8'h40, 8'h00);
        exp_reg(`DTU_REG_TCNT_LO, 8'h34);
        exp_reg(`DTU_REG_TCNT_HI, 8'h12);
        run_op(`DTU_OP_SET_BIT_IO, `DTU_IO_TMODE, 8'h05);
        run_op(`DTU_OP_LOAD_IO, `DTU_IO_TMODE, 8'h00);
        exp_reg(`DTU_REG_ACC, 8'h20);
        run_op(`DTU_OP_CLR_BIT_IO, `DTU_IO_TMODE, 8'h05);
        run_op(`DTU_OP_TIMER_TO_WORD, 8'hFF, 8'h00);
        rreg(`DTU_REG_TCNT_LO, rd2);
        exp_reg(`DTU_REG_TCNT_HI, mem.m[8'h00]);
        chk(mem.m[8'hFF], rd2);
        chk({mem.m[8'h00], rd2} > 16'h1234, 16'h0001);
    endtask : t_timer
    task automatic t_bits;
        io.m[8'h3F] = 8'h00;
        io.m[8'h40] = 8'h00;
        run_op(`DTU_OP_SET_BIT_IO, 8'h3F, 8'h07);
        chk({e, io.m[8'h3F]}, 9'h080);
        run_op(`DTU_OP_CLR_BIT_IO, 8'h3F, 8'h07);
        chk({e, io.m[8'h3F]}, 9'h000);
        run_op(`DTU_OP_SET_BIT_IO, 8'h40, 8'h00);
        chk({e, io.m[8'h40]}, 9'h100);
        exp_reg(`DTU_REG_STATUS, 8'h02);
        wreg(`DTU_REG_STATUS, 8'h02);
        exp_reg(`DTU_REG_STATUS, 8'h00);
        exp_reg(8'h18, 8'h00);
    endtask : t_bits
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_moves();
        t_alu();
        t_timer();
        t_bits();
        complete_run();
    end
endmodule : testbench
`default_nettype wire
